// ===== rtl/sptr_pkg.sv
// Operation
// - the pointer word is built from the two pointer bytes with the first byte as the upper half.
// - the low ten bits of the pointer word give the offset of the envelope start.
// - offset zero is the envelope byte right after the third pointer byte.
// - an offset above 782 is invalid and never used as a location.
// - pointer bytes are read only while frame alignment is held.
// - offsets number 87 envelope bytes per row from the row of H3, wrapping so 522 to 608 sit in row zero.
// - the envelope floats and may start in one frame and end in the next.
// - a slip buffer bridges two nearby line rates, so pointers may move by justification.
// - a positive justification puts a dummy byte after H3 and inverts the increment bits.
// - the frame after a positive justification carries the pointer plus one, increment bits normal.
// - a negative justification carries payload in H3 and inverts the decrement bits.
// - the frame after a negative justification carries the pointer minus one, decrement bits normal.
package sptr_pkg;
  // ----------------------------------------
  // frame geometry
  // ----------------------------------------
  localparam int unsigned ROWS_PER_FRAME = 9;
  localparam int unsigned COLS_PER_ROW   = 90;
  localparam int unsigned TOH_COLS       = 3;
  localparam int unsigned ENV_PER_ROW    = 87;
  localparam int unsigned PTR_ROW        = 3;
  localparam logic [9:0]  PTR_MAX        = 10'h30E;
  localparam logic [9:0]  PTR_RESET      = 10'h000;
  // ----------------------------------------
  // pointer word fields
  // ----------------------------------------
  localparam int unsigned PTR_LSB = 0;
  localparam int unsigned PTR_MSB = 9;
  localparam logic [9:0]  I_MASK  = 10'h2AA;
  localparam logic [9:0]  D_MASK  = 10'h155;

  typedef struct packed {
    logic       valid;
    logic       frame_start;
    logic [7:0] data;
  } sptr_byte_s;

  typedef struct packed {
    logic       valid;
    logic       j1;
    logic       stuff;
    logic [7:0] data;
  } sptr_out_s;
endpackage

// ===== rtl/sptr_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// two-stage synchroniser for pin inputs
// ----------------------------------------
module sptr_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end

  assign dout = s2_r;
endmodule // sptr_sync

// ===== rtl/sptr_locator.sv
`timescale 1ns/1ps
module sptr_locator (
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               frame_lock,
  input  sptr_pkg::sptr_byte_s    in_byte,
  output sptr_pkg::sptr_out_s     out_byte,
  output logic [9:0]              ptr_value,
  output logic                    ptr_invalid,
  output logic                    inc_pulse,
  output logic                    dec_pulse
);
  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  logic                 lock_s;
  sptr_pkg::sptr_byte_s ib;

  sptr_sync #(.W(1)) u_lock_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .din      (frame_lock),
    .dout     (lock_s)
  );

  sptr_sync #(.W(10)) u_byte_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .din      (in_byte),
    .dout     (ib)
  );

  // ----------------------------------------
  // frame position and pointer state
  // ----------------------------------------
  logic [3:0] row_r,     row_nxt;
  logic [6:0] col_r,     col_nxt;
  logic [7:0] h1_r,      h1_nxt;
  logic [9:0] ptr_r,     ptr_nxt;
  logic [9:0] env_r,     env_nxt;
  logic       inv_r,     inv_nxt;
  logic       inc_r,     inc_nxt;
  logic       dec_r,     dec_nxt;
  logic       pinc_r,    pinc_nxt;
  logic       pdec_r,    pdec_nxt;
  sptr_pkg::sptr_out_s ob_r, ob_nxt;

  // ----------------------------------------
  // position and pointer decode
  // ----------------------------------------
  logic [15:0] word;
  logic [9:0]  offs;
  logic [9:0]  dif;
  logic        in_ptr_row;
  logic        env_col;
  logic        is_h3;
  logic        after_h3;

  always_comb
  begin
    word       = {h1_r, ib.data};
    offs       = word[sptr_pkg::PTR_MSB:sptr_pkg::PTR_LSB];
    // bits that differ from the held pointer, tested against the I and D masks
    dif        = offs ^ ptr_r;
    in_ptr_row = (row_r == 4'(sptr_pkg::PTR_ROW));
    env_col    = (col_r >= 7'(sptr_pkg::TOH_COLS));
    is_h3      = in_ptr_row && (col_r == 7'(sptr_pkg::TOH_COLS - 1));
    after_h3   = in_ptr_row && (col_r == 7'(sptr_pkg::TOH_COLS));
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    row_nxt  = row_r;
    col_nxt  = col_r;
    h1_nxt   = h1_r;
    ptr_nxt  = ptr_r;
    env_nxt  = env_r;
    inv_nxt  = inv_r;
    inc_nxt  = 1'b0;
    dec_nxt  = 1'b0;
    pinc_nxt = pinc_r;
    pdec_nxt = pdec_r;
    ob_nxt   = '0;

    if (!lock_s)
    begin
      // counters parked until alignment returns; the held pointer survives
      row_nxt  = '0;
      col_nxt  = '0;
      pinc_nxt = 1'b0;
      pdec_nxt = 1'b0;
    end
    else if (ib.valid)
    begin
      // row and column of the next byte to leave the synchroniser
      if (ib.frame_start)
      begin
        row_nxt = 4'h0;
        col_nxt = 7'h01;
      end
      else if (col_r == 7'(sptr_pkg::COLS_PER_ROW - 1))
      begin
        col_nxt = 7'h00;
        row_nxt = (row_r == 4'(sptr_pkg::ROWS_PER_FRAME - 1)) ? 4'h0 : row_r + 4'h1;
      end
      else
      begin
        col_nxt = col_r + 7'h01;
      end

      // envelope offset counter, wraps to zero at the end of row two
      // the byte right after H3 takes offset zero
      if (is_h3)
      begin
        env_nxt = 10'h000;
      end
      else if (env_col && !ib.frame_start)
      begin
        env_nxt = (env_r == sptr_pkg::PTR_MAX) ? 10'h000 : env_r + 10'h001;
      end

      // first pointer byte held until the second one arrives
      if (in_ptr_row && col_r == 7'h00)
      begin
        h1_nxt = ib.data;
      end

      if (in_ptr_row && col_r == 7'h01)
      begin
        // pointer carried as just-adjusted value next frame
        // every I or D bit must be inverted against the held pointer; none is
        // honoured while that pointer is marked invalid
        pinc_nxt = 1'b0;
        pdec_nxt = 1'b0;
        if (!inv_r && (dif & sptr_pkg::I_MASK) == sptr_pkg::I_MASK && dif[0] == 1'b0)
        begin
          inc_nxt  = 1'b1;
          pinc_nxt = 1'b1;
          ptr_nxt  = (ptr_r == sptr_pkg::PTR_MAX) ? 10'h000 : ptr_r + 10'h001;
        end
        else if (!inv_r && (dif & sptr_pkg::D_MASK) == sptr_pkg::D_MASK && dif[1] == 1'b0)
        begin
          dec_nxt  = 1'b1;
          pdec_nxt = 1'b1;
          ptr_nxt  = (ptr_r == 10'h000) ? sptr_pkg::PTR_MAX : ptr_r - 10'h001;
        end
        else if (offs > sptr_pkg::PTR_MAX)
        begin
          inv_nxt = 1'b1;
        end
        else
        begin
          ptr_nxt = offs;
          inv_nxt = 1'b0;
        end
      end

      // output stream, marking J1 and justification bytes
      // on a negative justification the H3 byte carries payload and is passed on
      ob_nxt.valid = env_col || (is_h3 && pdec_r);
      ob_nxt.data  = ib.data;
      ob_nxt.stuff = after_h3 && pinc_r;
      if (is_h3 && pdec_r)
      begin
        ob_nxt.j1 = (ptr_r == sptr_pkg::PTR_MAX);
      end
      else if (env_col && !(after_h3 && pinc_r))
      begin
        ob_nxt.j1 = (env_r == ptr_r) && !(pdec_r && after_h3 && ptr_r == 10'h000);
      end
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      row_r  <= '0;
      col_r  <= '0;
      h1_r   <= '0;
      ptr_r  <= sptr_pkg::PTR_RESET;
      env_r  <= '0;
      inv_r  <= 1'b0;
      inc_r  <= 1'b0;
      dec_r  <= 1'b0;
      pinc_r <= 1'b0;
      pdec_r <= 1'b0;
      ob_r   <= '0;
    end
    else
    begin
      row_r  <= row_nxt;
      col_r  <= col_nxt;
      h1_r   <= h1_nxt;
      ptr_r  <= ptr_nxt;
      env_r  <= env_nxt;
      inv_r  <= inv_nxt;
      inc_r  <= inc_nxt;
      dec_r  <= dec_nxt;
      pinc_r <= pinc_nxt;
      pdec_r <= pdec_nxt;
      ob_r   <= ob_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign out_byte    = ob_r;
  assign ptr_value   = ptr_r;
  assign ptr_invalid = inv_r;
  assign inc_pulse   = inc_r;
  assign dec_pulse   = dec_r;
endmodule // sptr_locator

// ===== verification/sptr_locator_properties.sv
`timescale 1ns/1ps
module sptr_chk (
  input wire logic           core_clk,
  input wire logic           srst,
  input wire logic           frame_lock,
  input sptr_pkg::sptr_out_s out_byte,
  input wire logic [9:0]     ptr_value,
  input wire logic           ptr_invalid,
  input wire logic           inc_pulse,
  input wire logic           dec_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // lock pin low long enough to clear the synchroniser and output stage
  sequence unlocked_s;
    !frame_lock [*5];
  endsequence
  no_out_a: assert property (unlocked_s |-> !out_byte.valid) else $error("output unlocked");
  lock_hold_a: assert property (unlocked_s |-> $stable(ptr_value)) else $error("ptr moved");
  range_a: assert property (ptr_value <= 10'h30E) else $error("ptr out of range");
  hold_a: assert property ($rose(ptr_invalid) |-> $stable(ptr_value)) else $error("ptr lost");
  inc_single_a: assert property (inc_pulse |=> !inc_pulse) else $error("inc too long");
  dec_single_a: assert property (dec_pulse |=> !dec_pulse) else $error("dec too long");
  just_excl_a: assert property (!(inc_pulse && dec_pulse)) else $error("inc and dec");
  inc_step_a: assert property (inc_pulse |-> ptr_value ==
    (($past(ptr_value) == 10'h30E) ? 10'h000 : $past(ptr_value) + 10'h001))
    else $error("inc step wrong");
  dec_step_a: assert property (dec_pulse |-> ptr_value ==
    (($past(ptr_value) == 10'h000) ? 10'h30E : $past(ptr_value) - 10'h001))
    else $error("dec step wrong");
  j1_mark_a: assert property (out_byte.j1 |-> out_byte.valid && !out_byte.stuff)
    else $error("j1 on non payload");
endmodule // sptr_chk

bind sptr_locator sptr_chk u_chk (.core_clk(core_clk), .srst(srst), .frame_lock(frame_lock),
  .out_byte(out_byte), .ptr_value(ptr_value), .ptr_invalid(ptr_invalid),
  .inc_pulse(inc_pulse), .dec_pulse(dec_pulse));

// ===== verification/sptr_source.sv
`timescale 1ns/1ps
module sptr_source (
  input  wire logic            core_clk,
  input  wire logic            run,
  input  wire logic [15:0]     word,
  output sptr_pkg::sptr_byte_s in_byte
);
  logic [9:0] idx = 10'h000;
  logic       tog = 1'b0;
  always @(posedge core_clk)
  begin
    idx <= #1 (!run || idx == 10'h329) ? 10'h000 : idx + 10'h001;
    tog <= #1 ~tog;
  end
  // 810 bytes per frame, pointer bytes at row 3 columns 0 and 1
  always_comb
  begin
    in_byte.valid       = run;
    in_byte.frame_start = run && idx == 10'h000;
    in_byte.data        = run ? idx[7:0] : {8{tog}};
    if (run && idx == 10'h10E)
      in_byte.data = word[15:8];
    if (run && idx == 10'h10F)
      in_byte.data = word[7:0];
  end
endmodule // sptr_source

// ===== verification/test_sptr_locator.sv
`timescale 1ns/1ps
module test_sptr_locator;
  logic                 core_clk    = 1'b0;
  logic                 srst        = 1'b1;
  logic                 frame_lock  = 1'b0;
  logic                 run         = 1'b0;
  logic [15:0]          word        = 16'h0000;
  logic [7:0]           j1_data     = 8'h00;
  int                   num_errors  = 0;
  int                   comparisons = 0;
  int                   n_inc       = 0;
  int                   n_dec       = 0;
  int                   n_pay       = 0;
  int                   n_stuff     = 0;
  sptr_pkg::sptr_byte_s in_byte;
  sptr_pkg::sptr_out_s  out_byte;
  logic [9:0]           ptr_value;
  logic                 ptr_invalid;
  logic                 inc_pulse;
  logic                 dec_pulse;
  initial forever #10 core_clk = ~core_clk;
  sptr_source u_src (.core_clk(core_clk), .run(run), .word(word), .in_byte(in_byte));
  sptr_locator u_dut (.core_clk(core_clk), .srst(srst), .frame_lock(frame_lock),
    .in_byte(in_byte), .out_byte(out_byte), .ptr_value(ptr_value),
    .ptr_invalid(ptr_invalid), .inc_pulse(inc_pulse), .dec_pulse(dec_pulse));
  always @(posedge core_clk)
  begin
    if (out_byte.j1 === 1'b1)
      j1_data <= out_byte.data;
    if (inc_pulse === 1'b1)
      n_inc <= n_inc + 1;
    if (dec_pulse === 1'b1)
      n_dec <= n_dec + 1;
    if (out_byte.valid === 1'b1 && out_byte.stuff === 1'b0)
      n_pay <= n_pay + 1;
    if (out_byte.stuff === 1'b1)
      n_stuff <= n_stuff + 1;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one whole frame carrying pointer word w
  task automatic frame(input logic [15:0] w);
    word = w;
    repeat (810) @(posedge core_clk);
    #1;
  endtask
  task automatic t_offsets;
    frame(16'h0000);
    check(16'(ptr_value), 16'h0000);
    check(16'(j1_data), 16'h0011);
    frame(16'h0057);
    check(16'(j1_data), 16'h006B);
  endtask
  task automatic t_range;
    frame(16'hFF0E);
    check(16'(ptr_value), 16'h030E);
    check(16'(ptr_invalid), 16'h0000);
    frame(16'h030F);
    check(16'(ptr_invalid), 16'h0001);
    check(16'(ptr_value), 16'h030E);
    frame(16'h0064);
    check(16'(ptr_invalid), 16'h0000);
  endtask
  task automatic t_inc;
    int base;
    base = n_pay;
    frame(16'h02CE);
    check(16'(n_inc), 16'h0001);
    check(16'(n_stuff), 16'h0001);
    check(16'(n_pay - base), 16'h030E);
    check(16'(ptr_value), 16'h0065);
    base = n_pay;
    frame(16'h0065);
    check(16'(n_inc), 16'h0001);
    check(16'(n_stuff), 16'h0001);
    check(16'(n_pay - base), 16'h030F);
    check(16'(j1_data), 16'h0079);
  endtask
  task automatic t_dec;
    int base;
    base = n_pay;
    frame(16'h0130);
    check(16'(n_dec), 16'h0001);
    check(16'(n_stuff), 16'h0001);
    check(16'(n_pay - base), 16'h0310);
    check(16'(ptr_value), 16'h0064);
    base = n_pay;
    frame(16'h0064);
    check(16'(n_dec), 16'h0001);
    check(16'(n_pay - base), 16'h030F);
    check(16'(j1_data), 16'h0078);
  endtask
  task automatic t_unlock;
    frame_lock = 1'b0;
    frame(16'h0000);
    check(16'(ptr_value), 16'h0064);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    frame_lock = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    run = 1'b1;
    t_offsets;
    t_range;
    t_inc;
    t_dec;
    t_unlock;
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    give_verdict;
  end
endmodule // test_sptr_locator
